// File: logic/wpmw_decode.sv
// Purpose: holds and decodes the write-path mode word written by mode-set commands
// Assumes: command and address inputs are synchronous to clk_in, one cycle per command
// Notes: termination selection and latency counting run on every clock
// What this block does
// - cas write delay from word bits 5:3, codes select 9 to 20 clocks
// - write cas delay counts clocks from internal write to first data bit
// - only whole-clock latencies exist, no half-clock offsets
// - total write delay is added latency plus write cas delay
// - dynamic write termination from bits 11:9, applied during writes
// - in write-leveling only nominal termination is used
// - write crc enabled makes bursts ten unit intervals, last two carry crc
// - mode-set with select code 111 is ignored entirely
// - self-refresh range from bits 7:6 tunes self-refresh current
// - write termination applies even when nominal termination is off
// - word is addressed when select bits carry code 010
`include "wpmw_map.svh"
module wpmw_decode (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mode_set_command_in,
  input wire logic bank_group_select_bit_in,
  input wire logic [1:0] bank_addr_in,
  input wire logic [16:0] addr_in,
  input wire logic [2:0] added_latency_in,
  input wire logic write_level_in,
  input wire logic [2:0] nominal_termination_value_in,
  input wire logic write_cmd_in,
  input wire logic odt_in,
  output logic [16:0] write_path_mode_word_out,
  output wpmw_pkg::wpmw_cfg_t cfg_out,
  output logic [2:0] active_term_out,
  output logic data_expect_out,
  output logic loaded_out
);
  // ==========================================
  // decoding helpers
  // the code table lives in one place; the checker keeps its own arithmetic copy
  function automatic logic [4:0] cas_delay_decode(input logic [2:0] code);
    case (code)
      3'h0: cas_delay_decode = `WPMW_CASW_9;
      3'h1: cas_delay_decode = `WPMW_CASW_10;
      3'h2: cas_delay_decode = `WPMW_CASW_11;
      3'h3: cas_delay_decode = `WPMW_CASW_12;
      3'h4: cas_delay_decode = `WPMW_CASW_14;
      3'h5: cas_delay_decode = `WPMW_CASW_16;
      3'h6: cas_delay_decode = `WPMW_CASW_18;
      default: cas_delay_decode = `WPMW_CASW_20;
    endcase
  endfunction

  // select code compare, used for the own code and for the reserved one
  function automatic logic select_is(input logic [2:0] code, input logic [2:0] want);
    select_is = (code == want);
  endfunction

  // burst length in unit intervals for a given crc flag
  function automatic logic [3:0] burst_len(input logic crc_on);
    if (crc_on) begin
      burst_len = `WPMW_BURST_CRC;
    end else begin
      burst_len = `WPMW_BURST_PLAIN;
    end
  endfunction

  // ==========================================
  // mode word capture
  logic [16:0] word;
  logic [2:0] sel;
  logic sel_own;
  logic sel_reserved;
  logic hit;
  wpmw_pkg::wpmw_state_t state;

  assign sel = {bank_group_select_bit_in, bank_addr_in};
  assign sel_own = select_is(sel, `WPMW_SEL_THIS);
  assign sel_reserved = select_is(sel, `WPMW_SEL_RESERVED);
  // the reserved code belongs to register control words, so it gets no response
  assign hit = mode_set_command_in && sel_own && !sel_reserved;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word <= `WPMW_WORD_RESET;
    end else if (hit) begin
      // reserved bits stored as given; keeping them zero is up to the controller
      word <= addr_in;
    end
  end

  // loaded stays up until reset; nothing here ever unloads the word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= wpmw_pkg::WPMW_ST_IDLE;
    end else begin
      case (state)
        wpmw_pkg::WPMW_ST_IDLE: begin
          if (hit) begin
            state <= wpmw_pkg::WPMW_ST_LOADED;
          end
        end
        default: begin
          state <= wpmw_pkg::WPMW_ST_LOADED;
        end
      endcase
    end
  end

  // ==========================================
  // field decode
  logic [2:0] cas_code;
  logic [1:0] range_code;
  logic [2:0] dyn_code;
  logic crc_bit;
  wpmw_pkg::wpmw_cfg_t next_cfg;
  wpmw_pkg::wpmw_cfg_t cfg;

  assign cas_code = word[`WPMW_CASW_HI:`WPMW_CASW_LO];
  assign range_code = word[`WPMW_SRR_HI:`WPMW_SRR_LO];
  assign dyn_code = word[`WPMW_DTERM_HI:`WPMW_DTERM_LO];
  assign crc_bit = word[`WPMW_CRC_BIT];

  // cfg is registered, so it trails the word by one clock
  always_comb begin
    next_cfg = '0;
    next_cfg.write_cas_delay = cas_delay_decode(cas_code);
    // integer clocks only, so the sum stays whole
    next_cfg.total_write_delay =
      {3'h0, added_latency_in} + {1'b0, next_cfg.write_cas_delay};
    next_cfg.selfrefresh_range_select = wpmw_pkg::wpmw_srr_t'(range_code);
    next_cfg.dyn_term_value = dyn_code;
    next_cfg.crc_enable = crc_bit;
    next_cfg.burst_ui = burst_len(crc_bit);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ==========================================
  // write latency count
  // a new write restarts the count; overlapping writes lose the earlier pulse
  logic [5:0] lat_cnt;
  logic counting;
  logic expect_q;
  logic last_tick;

  assign last_tick = counting && (lat_cnt == `WPMW_CNT_ONE);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lat_cnt <= `WPMW_CNT_ZERO;
    end else if (write_cmd_in) begin
      // the command edge already spends one clock of the delay
      lat_cnt <= {1'b0, cfg.write_cas_delay} - `WPMW_CNT_ONE;
    end else if (counting) begin
      lat_cnt <= lat_cnt - `WPMW_CNT_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      counting <= 1'b0;
    end else if (write_cmd_in) begin
      counting <= 1'b1;
    end else if (last_tick) begin
      counting <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      expect_q <= 1'b0;
    end else begin
      // one-cycle pulse in the clock the first data bit is due
      expect_q <= !write_cmd_in && last_tick;
    end
  end

  // ==========================================
  // termination select
  // dynamic code zero means off, so the nominal value stays in force
  logic [2:0] term;
  logic [2:0] next_term;
  logic write_window;

  assign write_window = write_cmd_in || counting;

  always_comb begin
    next_term = `WPMW_TERM_OFF;
    if (write_level_in) begin
      next_term = nominal_termination_value_in;
    end else if (odt_in && write_window && (cfg.dyn_term_value != `WPMW_TERM_OFF)) begin
      // independent of the nominal value being off
      next_term = cfg.dyn_term_value;
    end else if (odt_in) begin
      next_term = nominal_termination_value_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      term <= `WPMW_TERM_OFF;
    end else begin
      term <= next_term;
    end
  end

  // ==========================================
  // outputs
  assign write_path_mode_word_out = word;
  assign cfg_out = cfg;
  assign active_term_out = term;
  assign data_expect_out = expect_q;
  assign loaded_out = (state == wpmw_pkg::WPMW_ST_LOADED);
endmodule // wpmw_decode

// File: logic/wpmw_map.svh
`ifndef WPMW_MAP_SVH
`define WPMW_MAP_SVH
// Purpose: field positions and codes of the write-path mode word decoder
// Assumes: included by the decoder only; the package does not include it
// Notes: constants only
`define WPMW_SEL_THIS 3'h2
`define WPMW_SEL_RESERVED 3'h7
`define WPMW_CASW_HI 5
`define WPMW_CASW_LO 3
`define WPMW_SRR_HI 7
`define WPMW_SRR_LO 6
`define WPMW_DTERM_HI 11
`define WPMW_DTERM_LO 9
`define WPMW_CRC_BIT 12
`define WPMW_WORD_RESET 17'h00000
`define WPMW_BURST_PLAIN 4'h8
`define WPMW_BURST_CRC 4'hA
`define WPMW_CASW_9 5'h09
`define WPMW_CASW_10 5'h0A
`define WPMW_CASW_11 5'h0B
`define WPMW_CASW_12 5'h0C
`define WPMW_CASW_14 5'h0E
`define WPMW_CASW_16 5'h10
`define WPMW_CASW_18 5'h12
`define WPMW_CASW_20 5'h14
`define WPMW_CNT_ZERO 6'h00
`define WPMW_CNT_ONE 6'h01
`define WPMW_TERM_OFF 3'h0
`endif

// File: logic/wpmw_pkg.sv
// Purpose: types for the write-path mode word decoder
// Assumes: nothing beyond the map header
// Notes: fields travel as one packed struct
package wpmw_pkg;
  typedef enum logic [1:0] {
    WPMW_SR_NORMAL,
    WPMW_SR_REDUCED,
    WPMW_SR_EXTENDED,
    WPMW_SR_AUTO
  } wpmw_srr_t;

  typedef struct packed {
    logic [4:0] write_cas_delay;
    logic [5:0] total_write_delay;
    wpmw_srr_t selfrefresh_range_select;
    logic [2:0] dyn_term_value;
    logic crc_enable;
    logic [3:0] burst_ui;
  } wpmw_cfg_t;

  typedef enum logic {
    WPMW_ST_IDLE,
    WPMW_ST_LOADED
  } wpmw_state_t;
endpackage

// File: dv/wpmw_decode_props.sv
// Purpose: port checks of the write-path mode word decoder
// Assumes: bound to wpmw_decode, one clock domain
// Notes: cfg lags the word by one clock, so field checks use a delayed word copy
module wpmw_decode_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mode_set_command_in,
  input wire logic bank_group_select_bit_in,
  input wire logic [1:0] bank_addr_in,
  input wire logic [16:0] addr_in,
  input wire logic [2:0] added_latency_in,
  input wire logic write_level_in,
  input wire logic [2:0] nominal_termination_value_in,
  input wire logic write_cmd_in,
  input wire logic [16:0] write_path_mode_word_out,
  input wire wpmw_pkg::wpmw_cfg_t cfg_out,
  input wire logic [2:0] active_term_out,
  input wire logic data_expect_out,
  input wire logic loaded_out
);
  logic [2:0] sel;
  logic [16:0] pw;
  logic [5:0] gap;
  function automatic logic [4:0] cas_delay(input logic [2:0] c);
    return c[2] ? 5'h06 + {1'b0, c, 1'b0} : 5'h09 + {2'h0, c};
  endfunction
  assign sel = {bank_group_select_bit_in, bank_addr_in};
  always_ff @(posedge clk_in) pw <= write_path_mode_word_out;
  // clocks since the last write command; wraps harmlessly long after any pulse
  always_ff @(posedge clk_in) gap <= rst_in ? 6'h00 : write_cmd_in ? 6'h01 : gap + 6'h01;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_word_taken: assert property (mode_set_command_in && sel == 3'h2
    |=> write_path_mode_word_out == $past(addr_in) && loaded_out) else $error("word not taken");
  chk_code_ignored: assert property (mode_set_command_in && sel == 3'h7
    |=> $stable(write_path_mode_word_out)) else $error("reserved code changed word");
  chk_cwl_decode: assert property (!$past(rst_in)
    |-> cfg_out.write_cas_delay == cas_delay(pw[5:3])) else $error("bad cas write delay");
  chk_total_sum: assert property (!$past(rst_in) |-> cfg_out.total_write_delay ==
    {3'h0, $past(added_latency_in)} + {1'b0, cas_delay(pw[5:3])}) else $error("bad total delay");
  chk_crc_burst: assert property (!$past(rst_in) |-> cfg_out.crc_enable == pw[12]
    && cfg_out.burst_ui == (pw[12] ? 4'hA : 4'h8)) else $error("bad burst length");
  chk_range_term: assert property (!$past(rst_in) |-> cfg_out.dyn_term_value == pw[11:9]
    && cfg_out.selfrefresh_range_select == pw[7:6]) else $error("bad range or term field");
  chk_level_nominal: assert property (write_level_in
    |=> active_term_out == $past(nominal_termination_value_in)) else $error("term not nominal");
  chk_expect_gap: assert property (data_expect_out
    |-> gap == {1'b0, cfg_out.write_cas_delay}) else $error("data expected at wrong clock");
  cov_word: cover property (mode_set_command_in && sel == 3'h2);
  cov_expect: cover property (data_expect_out);
  cov_crc: cover property (cfg_out.crc_enable);
endmodule // wpmw_decode_props

// File: dv/wpmw_ctrl_model.sv
// Purpose: controller side issuing mode-set commands
// Assumes: called at a falling edge, one command per call
// Notes: released lines show the inverse so stale values never pass
module wpmw_ctrl_model (
  input wire logic clk_in,
  output logic mode_set_command_out,
  output logic [2:0] sel_out,
  output logic [16:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {mode_set_command_out, sel_out, addr_out} = '0;
  task automatic send(input logic [2:0] sel, input logic [16:0] w);
    {mode_set_command_out, sel_out} = {1'b1, sel};
    addr_out = w & 17'h01EF8;
    @(negedge clk_in);
    mode_set_command_out = 1'b0;
    {sel_out, addr_out} = ~{sel_out, addr_out};
  endtask
endmodule // wpmw_ctrl_model

// File: dv/test_write_path_mode_word_decode.sv
// Purpose: self-checking bench of the write-path mode word decoder
// Assumes: inputs change at the falling edge
// Notes: expected values come from the latency table below
module test_write_path_mode_word_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, lvl = 1'b0, wr = 1'b0, odt = 1'b0, ms, de, ld;
  logic [2:0] lat_add = 3'h0, nom = 3'h0, sel, term;
  logic [16:0] addr, word;
  wpmw_pkg::wpmw_cfg_t cfg;
  int err_total = 0, tests_run = 0, n;
  int cas_tab [8] = '{9, 10, 11, 12, 14, 16, 18, 20};
  always #12.5 clk_in = ~clk_in;
  wpmw_ctrl_model u_ctrl (.clk_in(clk_in), .mode_set_command_out(ms), .sel_out(sel),
    .addr_out(addr));
  wpmw_decode dut_u (.clk_in(clk_in), .rst_in(rst_in), .mode_set_command_in(ms),
    .bank_group_select_bit_in(sel[2]), .bank_addr_in(sel[1:0]), .addr_in(addr),
    .added_latency_in(lat_add), .write_level_in(lvl), .nominal_termination_value_in(nom),
    .write_cmd_in(wr), .odt_in(odt), .write_path_mode_word_out(word), .cfg_out(cfg),
    .active_term_out(term), .data_expect_out(de), .loaded_out(ld));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    logic [16:0] w;
    void'($urandom(23));
    repeat (12) @(negedge clk_in);
    check(24'({word, ld}), 24'h0);
    rst_in = 1'b0;
    for (int c = 0; c < 8; c++) begin
      w = 17'($urandom) & 17'h01EF8;
      w[5:3] = 3'(c);
      lat_add = 3'($urandom);
      u_ctrl.send(3'h2, w);
      @(negedge clk_in);
      check(24'(word), 24'(w));
      check(24'(cfg), 24'({5'(cas_tab[c]), 6'(lat_add + cas_tab[c]), w[7:6], w[11:9], w[12],
        w[12] ? 4'hA : 4'h8}));
      {wr, odt} = 2'h3;
      @(negedge clk_in);
      wr = 1'b0;
      // nominal is off here, so the dynamic value must still appear
      check(24'(term), 24'(w[11:9]));
      n = 1;
      while (de !== 1'b1 && n < 40) begin
        @(negedge clk_in);
        n++;
      end
      check(24'(n), 24'(cas_tab[c]));
      if (n == 40) final_report();
      $display("latency code %0d done", c);
    end
    for (int k = 0; k < 8; k++) begin
      if (k != 2) u_ctrl.send(3'(k), 17'($urandom));
    end
    check(24'(word), 24'(w));
    $display("refused codes done");
    {lvl, wr} = 2'h3;
    nom = 3'($urandom);
    @(negedge clk_in);
    check(24'(term), 24'(nom));
    {lvl, wr} = 2'h0;
    $display("write leveling done");
    final_report();
  end
endmodule // test_write_path_mode_word_decode
bind wpmw_decode wpmw_decode_props u_props (.*);
